// >>> rtl/mal_alert.sv
// alert and fault-recording logic of a voltage and temperature supervisor
// assumes a serial slave engine in the same clock domain issuing one-cycle
// register strobes, and a sequencer issuing one-cycle conversion results
//
// Contract
// - status bits: 2.5V,12V,3.3V,supply,temperature
// - crossing a threshold sets status and alert
// - voltage outside window faults; limits 2Bh-32h
// - mask bit suppresses status and alert
// - status read clears in default/one-time modes
// - status read releases alert except comparator
// - comparator mode keeps bit 4 on read
// - persisting fault realerts after next conversion
// - global enable low keeps alert released
// - conversions continue while alert is asserted
// - alert is open-drain active low
// - default mode realerts until below hysteresis
// - one-time mode rearms below hysteresis
// - comparator alert follows temperature versus limit
// - hot limit at 39h resets to 50h
// - hysteresis at 3Ah resets to 41h
// - start bit low stops monitoring, bus alive
// - reset holds defaults, shutdown, ignores bus
// - mode field: 00,11 default; 01 one-time; 10 comparator
// - alert response does not clear alert
//
// register map in short
//   2bh..32h voltage limits, pairs of high then low, one pair per voltage source
//   39h hot limit, 3ah hot hysteresis, both signed degrees
//   40h configuration: bit 0 start, bit 1 alert enable, bit 3 alert clear, bit 7 soft reset
//   41h fault status, read clears; 43h fault mask; 44h temperature mode field in bits 1:0
//   unmapped indices read as zero and ignore writes
//
// behaviour notes
//   status bits and pending alert bits are kept apart: the alert clear bit drops
//   pending alerts but leaves the status the host has not read yet
//   the alert pin is released one edge after pending drops, so a host that polls
//   the wire right after its status read may still see it low for a cycle
//   results arriving while monitoring is stopped are dropped, not queued; the
//   sequencer is expected to stall on its own in shutdown
//   comparator mode keeps the temperature bit as a level, so status reads leave it
//   and only a result not above the hot limit clears it
//   default mode keeps refiring between hysteresis and limit once tripped; this
//   trades extra host traffic for never losing a warm excursion
//   one-time mode fires once per excursion; a host that misses it sees nothing more
//   until the temperature has gone below hysteresis and back above the limit
//
// limitations
//   the alert response acknowledge is accepted and deliberately ignored
//   the pin level input is not used: this block never arbitrates the shared line
//   soft reset acts one edge after its write, so a write in that edge is lost
`timescale 1ns/100ps
`timescale 1ns/100ps
`default_nettype none
`include "mal_cfg.svh"
module mal_alert
   import mal_pkg::*;
#(
   parameter int NUM_SRC = 5
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic ars_ack,
   input wire mal_result_t result,
   input wire logic alert_n_in,
   output logic alert_n_out,
   output logic alert_oe,
   output logic monitor_run
);
   // ==========================================================
   // elaboration checks
   initial
   begin
      if (NUM_SRC != 5)
         $error("mal_alert serves exactly five sources");
   end

   // ==========================================================
   // helpers
   // decode the two-bit mode field into the one-hot mode
   function automatic mal_tmode_t decode_mode(input logic [1:0] f);
      mal_tmode_t m;
      m = MAL_TM_DEFAULT;
      case (f)
         `MAL_MODE_ONETIME: m = MAL_TM_ONETIME;
         `MAL_MODE_COMPARE: m = MAL_TM_COMPARE;
         default: m = MAL_TM_DEFAULT; // 00 and 11
      endcase
      return m;
   endfunction

   // voltage limit slot: even byte high, odd byte low of a pair
   function automatic logic [7:0] vlim_get(input logic [63:0] v, input logic [2:0] i);
      return v[{i, 3'h0} +: 8];
   endfunction

   // ==========================================================
   // state
   mal_state_t state_ff; // all registered state
   mal_state_t nxt_state; // next value
   mal_tmode_t mode; // current temperature mode
   logic [2:0] vidx; // voltage limit slot index
   logic [4:0] vfault; // per-source fault of this result, bit 4 the temperature
   logic [7:0] clr_bits; // status bits a read clears
   logic status_rd; // host read of fault status
   logic temp_hot; // result above hot limit
   logic temp_cool; // result below hysteresis
   logic is_temp; // result is temperature

   assign mode = decode_mode(state_ff.temp_cfg[1:0]);
   assign status_rd = reg_rd && (reg_addr == `MAL_STATUS_ADDR);
   // sources 0..3 are the voltages, 4 the temperature
   assign is_temp = (result.source == 3'(`MAL_BIT_TEMP));
   // signed compare
   assign temp_hot = $signed(result.code) > $signed(state_ff.hot_limit);
   assign temp_cool = $signed(result.code) < $signed(state_ff.hot_hysteresis);
   assign vidx = {result.source[1:0], 1'b0};

   // ==========================================================
   // next-state logic
   // order of the overrides below matters:
   //   register writes first, then the status read clear,
   //   then the alert clear bit, then new results,
   //   so a fault in the cycle of a read is never lost;
   //   soft reset last, so it beats everything else
   // the read data mux looks at the address every cycle,
   // not only on a strobe; the bus holds the address for
   // the whole strobe, so the registered copy is the one
   // taken with the strobe
   always_comb
   begin
      nxt_state = state_ff;
      vfault = 5'h00;
      clr_bits = `MAL_SRC_MASK;
      // register writes; bus is ignored under reset by construction
      if (reg_wr)
      begin
         case (reg_addr)
            `MAL_HOT_LIMIT_ADDR: nxt_state.hot_limit = reg_wdata;
            `MAL_HOT_HYST_ADDR: nxt_state.hot_hysteresis = reg_wdata;
            `MAL_MASK_ADDR: nxt_state.fault_mask = reg_wdata & `MAL_SRC_MASK;
            `MAL_CONFIG_ADDR: nxt_state.config_reg = reg_wdata;
            `MAL_TEMP_CFG_ADDR: nxt_state.temp_cfg = reg_wdata;
            default:
            begin
               // voltage limits
               if (reg_addr >= `MAL_VLIM_FIRST && reg_addr <= `MAL_VLIM_LAST)
                  nxt_state.vlim[{3'(reg_addr - `MAL_VLIM_FIRST), 3'h0} +: 8] = reg_wdata;
            end
         endcase
      end
      // read data mux, registered for a flop output
      case (reg_addr)
         `MAL_HOT_LIMIT_ADDR: nxt_state.rdata = state_ff.hot_limit;
         `MAL_HOT_HYST_ADDR: nxt_state.rdata = state_ff.hot_hysteresis;
         `MAL_STATUS_ADDR: nxt_state.rdata = state_ff.fault_status;
         `MAL_MASK_ADDR: nxt_state.rdata = state_ff.fault_mask;
         `MAL_CONFIG_ADDR: nxt_state.rdata = state_ff.config_reg;
         `MAL_TEMP_CFG_ADDR: nxt_state.rdata = state_ff.temp_cfg;
         default:
         begin
            if (reg_addr >= `MAL_VLIM_FIRST && reg_addr <= `MAL_VLIM_LAST)
               nxt_state.rdata = vlim_get(state_ff.vlim, 3'(reg_addr - `MAL_VLIM_FIRST));
            else
               nxt_state.rdata = 8'h00; // unmapped reads zero
         end
      endcase
      // status read clears and releases alert; comparator bit 4 kept
      if (status_rd)
      begin
         if (mode == MAL_TM_COMPARE)
            clr_bits[`MAL_BIT_TEMP] = 1'b0;
         nxt_state.fault_status = state_ff.fault_status & ~clr_bits;
         nxt_state.pending = state_ff.pending & ~clr_bits[4:0];
      end
      // interrupt clear bit releases alert, status untouched
      if (state_ff.config_reg[`MAL_CFG_ICLR])
         nxt_state.pending = 5'h00;
      // monitoring runs only with start set and clear bit low
      nxt_state.run = state_ff.config_reg[`MAL_CFG_START]
         && !state_ff.config_reg[`MAL_CFG_ICLR];
      // results judged regardless of alert level
      if (result.valid && state_ff.run)
      begin
         if (is_temp)
         begin
            nxt_state.temp_over = temp_hot;
            case (mode)
               MAL_TM_COMPARE:
               begin
                  // level follows limit
                  vfault[`MAL_BIT_TEMP] = temp_hot;
                  if (!temp_hot)
                  begin
                     nxt_state.fault_status[`MAL_BIT_TEMP] = 1'b0;
                     nxt_state.pending[`MAL_BIT_TEMP] = 1'b0;
                  end
               end
               MAL_TM_ONETIME:
               begin
                  // fire once, rearm below hysteresis
                  vfault[`MAL_BIT_TEMP] = temp_hot && state_ff.temp_armed;
                  if (temp_hot)
                     nxt_state.temp_armed = 1'b0;
                  else if (temp_cool)
                     nxt_state.temp_armed = 1'b1;
               end
               default:
               begin
                  // refire each result until below hysteresis
                  if (temp_hot)
                     nxt_state.temp_armed = 1'b0;
                  else if (temp_cool)
                     nxt_state.temp_armed = 1'b1;
                  vfault[`MAL_BIT_TEMP] = temp_hot || !state_ff.temp_armed && !temp_cool;
               end
            endcase
         end
         else if (result.source < 3'(`MAL_BIT_TEMP))
         begin
            // outside the window
            vfault[result.source] =
               (result.code > vlim_get(state_ff.vlim, vidx))
               || (result.code < vlim_get(state_ff.vlim, vidx + 3'h1));
         end
         // masked sources record nothing
         vfault = vfault & ~state_ff.fault_mask[4:0];
         // set wins over a same-cycle read clear
         nxt_state.fault_status[4:0] = nxt_state.fault_status[4:0] | vfault;
         nxt_state.pending = nxt_state.pending | vfault;
      end
      // alert response acknowledge deliberately changes nothing
      // alert drive from unmasked pending and enable
      nxt_state.alert_oe = state_ff.config_reg[`MAL_CFG_IEN]
         && |(state_ff.pending & ~state_ff.fault_mask[4:0]);
      // self-clearing soft reset returns defaults
      if (state_ff.config_reg[`MAL_CFG_SOFTRST])
      begin
         nxt_state.hot_limit = `MAL_HOT_LIMIT_RST;
         nxt_state.hot_hysteresis = `MAL_HOT_HYST_RST;
         nxt_state.fault_status = `MAL_STATUS_RST;
         nxt_state.fault_mask = `MAL_MASK_RST;
         nxt_state.config_reg = `MAL_CONFIG_RST;
         nxt_state.temp_cfg = `MAL_TEMP_CFG_RST;
         nxt_state.vlim = {4{`MAL_VOLTAGE_LOW_LIMIT_RST, `MAL_VOLTAGE_HIGH_LIMIT_RST}};
         nxt_state.pending = 5'h00;
         nxt_state.temp_armed = 1'b1;
         nxt_state.alert_oe = 1'b0;
         nxt_state.run = 1'b0;
      end
   end

   // ==========================================================
   // state register; reset holds defaults and shutdown
   // the reset branch loads constants only, so release needs no
   // particular data on the bus; strobes under reset are lost
   // because the whole register is held, not because of gating
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff.hot_limit <= `MAL_HOT_LIMIT_RST;
         state_ff.hot_hysteresis <= `MAL_HOT_HYST_RST;
         state_ff.fault_status <= `MAL_STATUS_RST;
         state_ff.fault_mask <= `MAL_MASK_RST;
         state_ff.config_reg <= `MAL_CONFIG_RST;
         state_ff.temp_cfg <= `MAL_TEMP_CFG_RST;
         state_ff.vlim <= {4{`MAL_VOLTAGE_LOW_LIMIT_RST, `MAL_VOLTAGE_HIGH_LIMIT_RST}};
         state_ff.pending <= 5'h00;
         state_ff.temp_armed <= 1'b1;
         state_ff.temp_over <= 1'b0;
         state_ff.rdata <= 8'h00;
         state_ff.alert_oe <= 1'b0;
         state_ff.run <= 1'b0;
      end
      else
         state_ff <= nxt_state;
   end

   // ==========================================================
   // outputs; pin only pulled low
   // the pin data is tied low and only the enable moves, so the
   // line can be wired with other open-drain alert outputs
   // every output but the tied-low pin data is a register bit, none is decoded here
   assign reg_rdata = state_ff.rdata;
   assign alert_n_out = 1'b0;
   assign alert_oe = state_ff.alert_oe;
   assign monitor_run = state_ff.run;
endmodule
`default_nettype wire

// >>> rtl/mal_cfg.svh
// constants of the alert and fault-recording logic
// assumes inclusion by bare name from the package and the design
`ifndef MAL_CFG_SVH
`define MAL_CFG_SVH
// register offsets
`define MAL_VLIM_FIRST 8'h2b
`define MAL_VLIM_LAST 8'h32
`define MAL_HOT_LIMIT_ADDR 8'h39
`define MAL_HOT_HYST_ADDR 8'h3a
`define MAL_CONFIG_ADDR 8'h40
`define MAL_STATUS_ADDR 8'h41
`define MAL_MASK_ADDR 8'h43
`define MAL_TEMP_CFG_ADDR 8'h44
// reset values
`define MAL_HOT_LIMIT_RST 8'h50
`define MAL_HOT_HYST_RST 8'h41
`define MAL_STATUS_RST 8'h00
`define MAL_MASK_RST 8'h00
`define MAL_CONFIG_RST 8'h00
`define MAL_TEMP_CFG_RST 8'h00
// voltage limit reset values: 1.1 and 0.9 of nominal code 192
`define MAL_VOLTAGE_HIGH_LIMIT_RST 8'hd3
`define MAL_VOLTAGE_LOW_LIMIT_RST 8'had
// field positions
`define MAL_BIT_TEMP 4
`define MAL_CFG_START 0
`define MAL_CFG_IEN 1
`define MAL_CFG_ICLR 3
`define MAL_CFG_SOFTRST 7
`define MAL_SRC_MASK 8'h1f
// temperature alert mode codes
`define MAL_MODE_DEFAULT 2'h0
`define MAL_MODE_ONETIME 2'h1
`define MAL_MODE_COMPARE 2'h2
`endif

// >>> rtl/mal_pkg.sv
// types of the alert and fault-recording logic
// assumes mal_cfg.svh is on the include path
`include "mal_cfg.svh"
package mal_pkg;
   // one conversion result from the sequencer
   typedef struct packed
   {
      logic valid;
      logic [2:0] source;
      logic [7:0] code;
   } mal_result_t;
   // temperature alert mode
   typedef enum logic [2:0]
   {
      MAL_TM_DEFAULT = 3'h1,
      MAL_TM_ONETIME = 3'h2,
      MAL_TM_COMPARE = 3'h4
   } mal_tmode_t;
   // all block state
   typedef struct packed
   {
      logic [7:0] hot_limit;
      logic [7:0] hot_hysteresis;
      logic [7:0] fault_status;
      logic [7:0] fault_mask;
      logic [7:0] config_reg;
      logic [7:0] temp_cfg;
      logic [63:0] vlim;
      logic [4:0] pending;
      logic temp_armed;
      logic temp_over;
      logic [7:0] rdata;
      logic alert_oe;
      logic run;
   } mal_state_t;
endpackage

// >>> verification/mal_alert_assertions.sv
// port-level checker of the alert logic
// assumes binding onto mal_alert in one clock domain
`timescale 1ns/100ps
`default_nettype none
module mal_alert_chk
   import mal_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic ars_ack,
   input wire mal_result_t result,
   input wire logic alert_n_out,
   input wire logic alert_oe,
   input wire logic monitor_run
);
   // ==========
   // shadows of config writes; soft reset clears the limit and mode shadows one edge later, enable and run at its write
   logic quiet;
   logic wcfg;
   logic srst_ff;
   logic ien_ff;
   logic run_ff;
   logic hot_ff;
   logic hys_ff;
   logic cmp_ff;
   assign quiet = !reg_rd && !reg_wr && !result.valid;
   assign wcfg = reg_wr && reg_addr == 8'h40;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ien_ff <= 1'b0;
         run_ff <= 1'b0;
         hot_ff <= 1'b0;
         hys_ff <= 1'b0;
         cmp_ff <= 1'b0;
         srst_ff <= 1'b0;
      end
      else
      begin
         srst_ff <= wcfg && reg_wdata[7];
         if (wcfg) ien_ff <= reg_wdata[1] & ~reg_wdata[7];
         if (wcfg) run_ff <= reg_wdata[0] & ~reg_wdata[3] & ~reg_wdata[7];
         if (reg_wr && reg_addr == 8'h39) hot_ff <= 1'b1;
         if (reg_wr && reg_addr == 8'h3a) hys_ff <= 1'b1;
         if (reg_wr && reg_addr == 8'h44) cmp_ff <= reg_wdata[1:0] == 2'h2;
         // soft reset lands one edge after its write
         if (srst_ff)
         begin
            hot_ff <= 1'b0;
            hys_ff <= 1'b0;
            cmp_ff <= 1'b0;
         end
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_pin_open_drain:
      assert property (alert_oe |-> !alert_n_out) else $error("alert pin driven high");
   a_disabled_quiet:
      assert property (!ien_ff [*3] |-> !alert_oe) else $error("alert while disabled");
   a_read_releases:
      assert property ($past(quiet) && reg_rd && !reg_wr && !result.valid && !cmp_ff
         && reg_addr == 8'h41 ##1 quiet [*2] |=> !alert_oe) else $error("read kept alert");
   a_ars_ignored:
      assert property (quiet && $past(quiet) && ars_ack && alert_oe |=> alert_oe)
         else $error("alert response cleared alert");
   a_run_follows:
      assert property (!wcfg [*2] |-> monitor_run == run_ff) else $error("run mismatch");
   a_hot_default:
      assert property (reg_addr == 8'h39 && !hot_ff && !reg_wr |=> reg_rdata == 8'h50)
         else $error("hot limit default");
   a_hyst_default:
      assert property (reg_addr == 8'h3a && !hys_ff && !reg_wr |=> reg_rdata == 8'h41)
         else $error("hysteresis default");
   a_status_reserved:
      assert property (reg_addr == 8'h41 |=> reg_rdata[7:5] == 3'h0)
         else $error("status reserved bits set");
   c_alert_rise: cover property ($rose(alert_oe));
   c_cmp_read: cover property (cmp_ff && reg_rd && alert_oe);
   c_ars_seen: cover property (ars_ack && alert_oe);
endmodule
bind mal_alert mal_alert_chk mal_alert_chk_i
(
   .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ars_ack(ars_ack), .result(result),
   .alert_n_out(alert_n_out), .alert_oe(alert_oe), .monitor_run(monitor_run)
);
`default_nettype wire

// >>> verification/mal_host.sv
// host model: register writes and register reads
// assumes strobes are taken on the rising clock
`timescale 1ns/100ps
`default_nettype none
module mal_host
(
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   // ==========
   // bus idle at time zero
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // strobe spans one rising edge; lines scrambled once released
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(negedge clk);
      reg_wr = w;
      reg_rd = !w; // a transfer is either a write or a read
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      q = reg_rdata;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench of the alert logic
// assumes mal_host on the register port and a pull-up on the alert wire
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench
   import mal_pkg::*;
;
   logic clk;
   logic reset_n;
   logic ars_ack;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [7:0] q;
   logic alert_n_out;
   logic alert_oe;
   logic monitor_run;
   wire logic alert_line;
   mal_result_t result;
   int bad_count;
   int checked;
   int status;
   int mask;
   int ien;
   int run;
   int mode;
   int tripped;
   int armed = 1;
   int cyc;
   logic [7:0] tc[6] = '{8'h51, 8'h48, 8'h30, 8'h90, 8'h51, 8'h30};
   logic [15:0] rv[5] = '{16'h3950, 16'h3a41, 16'h4100, 16'h4300, 16'h5000};
   // ==========
   // wired line with pull-up
   assign alert_line = alert_oe ? alert_n_out : 1'b1;
   mal_host mal_host_i (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   mal_alert mal_alert_i (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ars_ack(ars_ack),
      .result(result), .alert_n_in(alert_line), .alert_n_out(alert_n_out),
      .alert_oe(alert_oe), .monitor_run(monitor_run));
   task automatic complete_run();
      $display("checks %0d errors %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      mal_host_i.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, e);
      mal_host_i.xfer(1'b0, a, 8'h00, q);
      `CHK("rdata", e, q)
   endtask
   // alert settles a few cycles after its cause
   task automatic al();
      repeat (4) @(negedge clk);
      `CHK("alert", 1'(ien == 0 || status == 0), alert_line)
   endtask
   // read-clear keeps bit 4 only in comparator mode
   task automatic rs();
      rd(8'h41, 8'(status));
      status = mode == 2 ? status & 16 : 0;
      al();
   endtask
   // one conversion result, then the model's view of it
   task automatic res(input int s, input logic [7:0] c);
      int t;
      int f;
      f = 0;
      @(negedge clk);
      result = '{1'b1, 3'(s), c};
      @(negedge clk);
      result = '{1'b0, 3'(~s), ~c};
      if (run && s == 4)
      begin
         t = $signed(c);
         if (t > 80) tripped = 1;
         if (t < 65) tripped = 0;
         f = mode == 1 ? armed && t > 80 : mode == 2 ? t > 80 : tripped;
         if (mode == 1 && f) armed = 0;
         if (t < 65) armed = 1;
         if (mode == 2) status[4] = 0;
      end
      else if (run) f = c > 8'hd3 || c < 8'had;
      if (f && !mask[s]) status[s] = 1;
      al();
   endtask
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         complete_run();
      end
   end
   initial
   begin
      reset_n = 1'b0;
      ars_ack = 1'b0;
      result = '0;
      void'($urandom(77809));
      repeat (16) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      foreach (rv[i]) rd(rv[i][15:8], rv[i][7:0]);
      for (int k = 0; k < 8; k++) rd(8'(8'h2b + k), k % 2 ? 8'had : 8'hd3);
      wr(8'h40, 8'h02);
      ien = 1;
      res(0, 8'hff);
      `CHK("run", 1'b0, monitor_run)
      wr(8'h40, 8'h03);
      run = 1;
      al();
      `CHK("run", 1'b1, monitor_run)
      for (int k = 0; k < 4; k++)
      begin
         res(k, 8'hd4 + 8'($urandom % 43));
         rs();
         res(k, 8'hac - 8'($urandom % 32));
         rs();
         res(k, 8'hc0);
         rs();
         res(k, 8'hff);
      end
      ars_ack = 1'b1;
      @(negedge clk);
      ars_ack = 1'b0;
      al();
      rs(); // host clears by a status read
      wr(8'h40, 8'h01);
      ien = 0;
      res(2, 8'hff);
      wr(8'h40, 8'h03);
      ien = 1;
      al();
      rs();
      mask = $urandom % 32;
      wr(8'h43, 8'(mask));
      rd(8'h43, 8'(mask));
      for (int k = 0; k < 5; k++) res(k, k < 4 ? 8'hff : 8'h7f);
      rs();
      wr(8'h43, 8'h00);
      mask = 0;
      for (int m = 0; m < 4; m++)
      begin
         wr(8'h44, 8'(m));
         mode = m % 3;
         foreach (tc[i])
         begin
            res(4, tc[i]);
            rs();
         end
      end
      // alert clear bit: alert drops, status kept, loop stops
      res(1, 8'hff);
      wr(8'h40, 8'h0b);
      run = 0;
      repeat (4) @(negedge clk);
      `CHK("iclr alert", 1'b1, alert_line)
      `CHK("iclr run", 1'b0, monitor_run)
      rs();
      // soft reset returns limits and config to defaults
      wr(8'h39, 8'h20);
      rd(8'h39, 8'h20);
      wr(8'h40, 8'h83);
      ien = 0;
      rd(8'h40, 8'h00);
      rd(8'h39, 8'h50);
      // mid-run power-on reset ignores a write made under it
      @(negedge clk);
      reset_n = 1'b0;
      wr(8'h3a, 8'h11);
      reset_n = 1'b1;
      rd(8'h3a, 8'h41);
      `CHK("reset run", 1'b0, monitor_run)
      complete_run();
   end
endmodule
`default_nettype wire
